/* File: hdl/pdlc_pkg.sv */
// constants, field layout, types and helpers of the synthesizer divider and lock core
// assumes one 50 MHz system clock; software reaches the registers over apb

package pdlc_pkg;

	// ---------------------------------------------------------------
	// widths and divider constants
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int RATIO_W = 18;
	localparam int SW_W = 5;
	localparam int MAIN_W = 14;
	localparam int REF_W = 11;
	localparam logic [RATIO_W-1:0] RATIO_MIN = 18'h00800;
	localparam logic [SW_W-1:0] PRE_LO_LAST = 5'h1E; // modulus 31
	localparam logic [SW_W-1:0] PRE_HI_LAST = 5'h1F; // modulus 32
	localparam logic [MAIN_W-1:0] MAIN_LAST = 14'h0001;
	localparam logic [MAIN_W-1:0] MAIN_RESET = 14'h0040; // 2048 / 32
	localparam logic [REF_W-1:0] REF_RESET = 11'h07F;
	localparam logic [1:0] DIV8_LAST = 2'h3;

	// ---------------------------------------------------------------
	// register map and fields
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_A = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_B = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_C = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_D = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
	localparam int A_PD_BIT = 7;
	localparam int A_PUMP_CURRENT_SEL_BIT = 5;
	localparam int B_POL_BIT = 7;
	localparam int B_VCO_SWITCH_B_BIT = 6;
	localparam int B_DI_BIT = 5;
	localparam int ST_NOW_BIT = 4;
	localparam int ST_LOOL_BIT = 2;
	localparam int ST_LPD_BIT = 1;
	localparam int ST_DI_BIT = 0;
	localparam logic [7:0] A_RESET = 8'h0E;
	localparam logic [7:0] BCD_RESET = 8'h00;

	// ---------------------------------------------------------------
	// lock detector timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int LOCK_ERR_NS = 200;
	localparam int LOCK_ERR_CYC = (LOCK_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] LOCK_ERR_LAST = 4'(LOCK_ERR_CYC - 1);
	localparam int LOCK_GOOD_REFS = 6;
	localparam logic [2:0] LOCK_GOOD_LAST = 3'(LOCK_GOOD_REFS - 1);

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_ACC = 2'b10
	} pdlc_apb_st_t;

	typedef struct packed {
		logic [2:0] rf_sync; // first, second, previous
		logic [2:0] osc_sync;
		logic [1:0] sleep_sync;
		logic [1:0] dip_sync;
		logic [7:0] reg_a;
		logic [7:0] reg_b;
		logic [7:0] reg_c;
		logic [7:0] reg_d;
		logic upd_pend;
		logic [RATIO_W-1:0] act_ratio;
		logic [SW_W-1:0] pres_cnt;
		logic [SW_W-1:0] sw_cnt;
		logic [MAIN_W-1:0] main_cnt;
		logic div_pulse;
		logic [REF_W-1:0] ref_cnt;
		logic ref_pulse;
		logic [1:0] div8_cnt;
		logic div8_out;
		logic pfd_ref;
		logic pfd_var;
		logic pump_up;
		logic pump_dn;
		logic pump_hiz;
		logic [3:0] err_cnt;
		logic cyc_bad;
		logic [2:0] good_cnt;
		logic unlock;
		logic lool;
		logic lpd;
		logic vco_switch_a_unlock_oe_n;
		logic alarm_oe_n;
		pdlc_apb_st_t st;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pdlc_state_t;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [REF_W-1:0] ref_ratio(input logic [3:0] sel);
		case (sel)
			4'h0: ref_ratio = 11'h080;
			4'h1: ref_ratio = 11'h0A0;
			4'h2: ref_ratio = 11'h0C0;
			4'h3: ref_ratio = 11'h0F0;
			4'h4: ref_ratio = 11'h100;
			4'h5: ref_ratio = 11'h140;
			4'h6: ref_ratio = 11'h180;
			4'h7: ref_ratio = 11'h1E0;
			4'h8: ref_ratio = 11'h200;
			4'h9: ref_ratio = 11'h280;
			4'hA: ref_ratio = 11'h300;
			4'hB: ref_ratio = 11'h3C0;
			4'hC: ref_ratio = 11'h400;
			4'hD: ref_ratio = 11'h500;
			4'hE: ref_ratio = 11'h600;
			default: ref_ratio = 11'h780;
		endcase
	endfunction : ref_ratio

endpackage : pdlc_pkg

/* File: hdl/pdlc_top.sv */
// synthesizer digital core: main and reference dividers, phase detector, lock detector
// assumes rf and oscillator arrive as slow-enough pins sampled by the 50 MHz clock,
// and an apb master on the same clock
`timescale 1ns/1ps
`default_nettype none

module pdlc_top (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [pdlc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rf_i,
	input wire logic osc_i,
	input wire logic hw_sleep_n_i,
	input wire logic power_dip_i,
	output logic pump_up_o,
	output logic pump_dn_o,
	output logic pump_hiz_o,
	output logic pump_current_sel_o,
	output logic vco_switch_a_unlock_o,
	output logic vco_switch_a_unlock_oe_n_o,
	output logic synth_alarm_n_o,
	output logic synth_alarm_n_oe_n_o,
	output logic vco_switch_b_o,
	output logic osc_div8_out_o
);

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_sync;
	logic rst_n;

	// assert at once, release after two clean edges
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ---------------------------------------------------------------
	// derived terms
	// ---------------------------------------------------------------
	pdlc_pkg::pdlc_state_t q;
	pdlc_pkg::pdlc_state_t next_q;
	logic rf_rise;
	logic osc_rise;
	logic sleep;
	logic [pdlc_pkg::RATIO_W-1:0] ratio_buf;
	logic setup;
	logic done;
	logic hit;
	logic stat_rd;
	logic [7:0] rd_byte;

	// edge detects read the second and third stages of each synchroniser, never the first
	assign rf_rise = q.rf_sync[1] & ~q.rf_sync[2];
	assign osc_rise = q.osc_sync[1] & ~q.osc_sync[2];
	assign sleep = ~q.sleep_sync[1] | q.reg_a[pdlc_pkg::A_PD_BIT];
	assign ratio_buf = {q.reg_b[1:0], q.reg_c, q.reg_d};
	assign setup = psel_i & ~penable_i;
	assign done = psel_i & penable_i & q.pready;
	assign stat_rd = done & ~pwrite_i & (paddr_i == pdlc_pkg::OFF_STAT);

	// read mux; status byte packs live and latched lock information
	always_comb begin
		hit = 1'b1;
		case (paddr_i)
			pdlc_pkg::OFF_A: rd_byte = q.reg_a;
			pdlc_pkg::OFF_B: rd_byte = q.reg_b;
			pdlc_pkg::OFF_C: rd_byte = q.reg_c;
			pdlc_pkg::OFF_D: rd_byte = q.reg_d;
			pdlc_pkg::OFF_STAT: begin
				rd_byte = 8'h00;
				rd_byte[pdlc_pkg::ST_NOW_BIT] = q.unlock;
				rd_byte[pdlc_pkg::ST_LOOL_BIT] = q.lool;
				rd_byte[pdlc_pkg::ST_LPD_BIT] = q.lpd;
				rd_byte[pdlc_pkg::ST_DI_BIT] = q.reg_b[pdlc_pkg::B_DI_BIT];
			end
			default: begin
				rd_byte = 8'h00;
				hit = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [pdlc_pkg::SW_W-1:0] sw_dec;
		logic [pdlc_pkg::RATIO_W-1:0] new_ratio;
		logic ref_f;
		logic var_f;
		logic err;
		logic over;
		sw_dec = '0;
		new_ratio = '0;
		ref_f = 1'b0;
		var_f = 1'b0;
		err = 1'b0;
		over = 1'b0;
		next_q = q;

		// pin synchronisers
		next_q.rf_sync = {q.rf_sync[1:0], rf_i};
		next_q.osc_sync = {q.osc_sync[1:0], osc_i};
		next_q.sleep_sync = {q.sleep_sync[0], hw_sleep_n_i};
		next_q.dip_sync = {q.dip_sync[0], power_dip_i};
		next_q.div_pulse = 1'b0;
		next_q.ref_pulse = 1'b0;

		// pulse-swallow divider; frozen while asleep so it resumes where it stood
		if (!sleep && rf_rise) begin
			if (q.pres_cnt == '0) begin // prescaler output
				sw_dec = (q.sw_cnt != '0) ? q.sw_cnt - 5'h01 : q.sw_cnt;
				if (q.main_cnt == pdlc_pkg::MAIN_LAST) begin
					next_q.div_pulse = 1'b1;
					// swap ratio only on the output pulse
					if (q.upd_pend) begin
						// small values fold up by the minimum
						new_ratio = (ratio_buf < pdlc_pkg::RATIO_MIN) ?
							ratio_buf + pdlc_pkg::RATIO_MIN : ratio_buf;
					end else begin
						new_ratio = q.act_ratio;
					end
					next_q.act_ratio = new_ratio;
					next_q.upd_pend = 1'b0;
					// 31/32 needs one more main cycle and 32-r swallow cycles
					if (new_ratio[pdlc_pkg::SW_W-1:0] == '0) begin
						next_q.main_cnt = {1'b0, new_ratio[pdlc_pkg::RATIO_W-1:pdlc_pkg::SW_W]};
						next_q.sw_cnt = '0;
					end else begin
						next_q.main_cnt = {1'b0, new_ratio[pdlc_pkg::RATIO_W-1:pdlc_pkg::SW_W]}
							+ pdlc_pkg::MAIN_LAST;
						next_q.sw_cnt = 5'h00 - new_ratio[pdlc_pkg::SW_W-1:0];
					end
				end else begin
					next_q.main_cnt = q.main_cnt - pdlc_pkg::MAIN_LAST;
					next_q.sw_cnt = sw_dec;
				end
				// alternate modulus while swallow count remains
				next_q.pres_cnt = (next_q.sw_cnt != '0) ?
					pdlc_pkg::PRE_LO_LAST : pdlc_pkg::PRE_HI_LAST;
			end else begin
				next_q.pres_cnt = q.pres_cnt - 5'h01;
			end
		end

		// reference divider and divide-by-eight output
		if (!sleep && osc_rise) begin
			if (q.ref_cnt == '0) begin
				next_q.ref_pulse = 1'b1;
				next_q.ref_cnt = pdlc_pkg::ref_ratio(q.reg_a[3:0]) - 11'h001;
			end else begin
				next_q.ref_cnt = q.ref_cnt - 11'h001;
			end
			next_q.div8_cnt = q.div8_cnt + 2'h1;
			if (q.div8_cnt == pdlc_pkg::DIV8_LAST) begin
				next_q.div8_out = ~q.div8_out;
			end
		end

		// tri-state detector: the leader raises its flag, both together reset
		ref_f = q.pfd_ref | q.ref_pulse;
		var_f = q.pfd_var | q.div_pulse;
		if ((ref_f && var_f) || sleep) begin
			ref_f = 1'b0;
			var_f = 1'b0;
		end
		next_q.pfd_ref = ref_f;
		next_q.pfd_var = var_f;
		// reference leading means up, unless polarity swaps
		next_q.pump_up = q.reg_b[pdlc_pkg::B_POL_BIT] ? var_f : ref_f;
		next_q.pump_dn = q.reg_b[pdlc_pkg::B_POL_BIT] ? ref_f : var_f;
		next_q.pump_hiz = ~(ref_f | var_f);

		// lock detector: error width counted in clock cycles
		err = q.pump_up | q.pump_dn;
		over = err && (q.err_cnt == pdlc_pkg::LOCK_ERR_LAST);
		if (!err) begin
			next_q.err_cnt = '0;
		end else if (!over) begin
			next_q.err_cnt = q.err_cnt + 4'h1;
		end
		if (q.ref_pulse) begin
			next_q.cyc_bad = 1'b0;
			if (q.cyc_bad) begin
				next_q.good_cnt = '0;
			end else if (q.unlock) begin
				if (q.good_cnt == pdlc_pkg::LOCK_GOOD_LAST) begin
					next_q.unlock = 1'b0;
					next_q.good_cnt = '0;
				end else begin
					next_q.good_cnt = q.good_cnt + 3'h1;
				end
			end
		end
		if (over) begin // immediate, and wins over a release
			next_q.unlock = 1'b1;
			next_q.cyc_bad = 1'b1;
			next_q.good_cnt = '0;
		end
		next_q.vco_switch_a_unlock_oe_n = ~next_q.unlock;

		// apb slave: no wait state, yet read data still comes from a flop
		case (q.st)
			pdlc_pkg::APB_IDLE: begin
				if (setup) begin
					next_q.prdata = {24'h000000, rd_byte};
					next_q.pslverr = ~hit;
					next_q.pready = 1'b1;
					next_q.st = pdlc_pkg::APB_ACC;
				end
			end
			pdlc_pkg::APB_ACC: begin
				if (done || !psel_i) begin
					next_q.pready = 1'b0;
					next_q.pslverr = 1'b0;
					next_q.st = pdlc_pkg::APB_IDLE;
				end
			end
			default: begin
				next_q.pready = 1'b0;
				next_q.st = pdlc_pkg::APB_IDLE;
			end
		endcase
		// registers keep working in power-down
		if (done && pwrite_i) begin
			case (paddr_i)
				pdlc_pkg::OFF_A: next_q.reg_a = pwdata_i[7:0];
				pdlc_pkg::OFF_B: next_q.reg_b = pwdata_i[7:0];
				pdlc_pkg::OFF_C: next_q.reg_c = pwdata_i[7:0];
				pdlc_pkg::OFF_D: begin
					next_q.reg_d = pwdata_i[7:0];
					next_q.upd_pend = 1'b1; // lowest byte arms the transfer
				end
				default: next_q.upd_pend = next_q.upd_pend;
			endcase
		end
		if (stat_rd) begin
			next_q.lool = 1'b0;
			next_q.lpd = 1'b0;
		end
		// a new event in the read cycle survives the clear
		if (next_q.unlock) begin
			next_q.lool = 1'b1;
		end
		if (q.dip_sync[1]) begin
			next_q.lpd = 1'b1;
		end
		next_q.alarm_oe_n = ~((next_q.lool | next_q.lpd) &
			~next_q.reg_b[pdlc_pkg::B_DI_BIT]);
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.reg_a <= pdlc_pkg::A_RESET;
			q.reg_b <= pdlc_pkg::BCD_RESET;
			q.reg_c <= pdlc_pkg::BCD_RESET;
			q.reg_d <= pdlc_pkg::BCD_RESET;
			q.act_ratio <= pdlc_pkg::RATIO_MIN;
			q.main_cnt <= pdlc_pkg::MAIN_RESET;
			q.pres_cnt <= pdlc_pkg::PRE_HI_LAST;
			q.ref_cnt <= pdlc_pkg::REF_RESET;
			q.pump_hiz <= 1'b1;
			q.vco_switch_a_unlock_oe_n <= 1'b1;
			q.alarm_oe_n <= 1'b1;
			q.st <= pdlc_pkg::APB_IDLE;
		end else begin
			q <= next_q;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all straight from the state register
	// ---------------------------------------------------------------
	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign pump_up_o = q.pump_up;
	assign pump_dn_o = q.pump_dn;
	assign pump_hiz_o = q.pump_hiz;
	assign pump_current_sel_o = q.reg_a[pdlc_pkg::A_PUMP_CURRENT_SEL_BIT];
	assign vco_switch_a_unlock_o = q.lpd & ~q.lpd; // open collector only ever pulls low
	assign vco_switch_a_unlock_oe_n_o = q.vco_switch_a_unlock_oe_n;
	assign synth_alarm_n_o = q.lool & ~q.lool;
	assign synth_alarm_n_oe_n_o = q.alarm_oe_n;
	assign vco_switch_b_o = q.reg_b[pdlc_pkg::B_VCO_SWITCH_B_BIT];
	assign osc_div8_out_o = q.div8_out;

	// ---------------------------------------------------------------
	// assertion helpers
	// ---------------------------------------------------------------
	// counted apart from err_cnt on purpose, so a broken detector counter
	// cannot hide behind its own value
	localparam logic [3:0] ERR_RUN_FULL = 4'(pdlc_pkg::LOCK_ERR_CYC);
	logic [3:0] err_run;

	// consecutive cycles with a pump active, saturating at the error width
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			err_run <= 4'h0;
		end else if (!(q.pump_up || q.pump_dn)) begin
			err_run <= 4'h0;
		end else if (err_run != ERR_RUN_FULL) begin
			err_run <= err_run + 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// assertions and covers
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);

	chk_pump_excl: assert property (!(q.pump_up && q.pump_dn))
		else $error("up and down pumps both active");
	chk_pump_hiz: assert property (q.pump_hiz == !(q.pump_up || q.pump_dn))
		else $error("pump high impedance state wrong");
	chk_ratio_range: assert property (q.act_ratio >= pdlc_pkg::RATIO_MIN)
		else $error("active ratio below minimum");
	chk_ratio_sync: assert property ($changed(q.act_ratio) |->
		q.div_pulse && $past(q.upd_pend))
		else $error("ratio changed away from divider pulse");
	chk_unlock_fast: assert property (err_run == ERR_RUN_FULL |-> q.unlock)
		else $error("long phase error not flagged");
	chk_unlock_release: assert property ($fell(q.unlock) |->
		$past(q.ref_pulse) && $past(q.good_cnt) == pdlc_pkg::LOCK_GOOD_LAST)
		else $error("unlock released too early");
	chk_vco_switch_a_unlock_pin: assert property (q.vco_switch_a_unlock_oe_n != q.unlock)
		else $error("vco switch a disagrees with unlock");
	chk_alarm_latch: assert property ($fell(q.lool) |-> $past(stat_rd))
		else $error("latched unlock cleared without status read");
	chk_sleep_freeze: assert property (sleep |=> $stable(q.main_cnt) && !q.div_pulse)
		else $error("divider ran during power-down");
	chk_ref_reload: assert property (q.ref_pulse |-> q.ref_cnt ==
		pdlc_pkg::ref_ratio($past(q.reg_a[3:0])) - 11'h001)
		else $error("reference divider reloaded wrong ratio");

	// the fold of small ratios, the arming write, power-down pumps, div8 cadence
	chk_ratio_fold: assert property ($changed(q.act_ratio) &&
		$past(ratio_buf) < pdlc_pkg::RATIO_MIN |->
		q.act_ratio == $past(ratio_buf) + pdlc_pkg::RATIO_MIN)
		else $error("small ratio not folded up");
	chk_upd_arm: assert property (done && pwrite_i && (paddr_i == pdlc_pkg::OFF_D) |=>
		q.upd_pend)
		else $error("lowest ratio byte did not arm the update");
	chk_sleep_pumps: assert property (sleep |=>
		!q.pump_up && !q.pump_dn && q.pump_hiz)
		else $error("pump active during power-down");
	chk_div8_step: assert property ($changed(q.div8_out) |->
		$past(osc_rise) && $past(q.div8_cnt) == pdlc_pkg::DIV8_LAST)
		else $error("divide by eight output stepped off cadence");

	cov_unlock: cover property ($rose(q.unlock));
	cov_relock: cover property ($fell(q.unlock));
	cov_new_ratio: cover property ($changed(q.act_ratio));
	cov_alarm_read: cover property (stat_rd && q.lool);
	cov_sleep: cover property ($rose(sleep));

endmodule : pdlc_top

`default_nettype wire

/* File: sim/pdlc_vco_model.sv */
// behavioural vco and loop filter on the far side of the synthesizer core
// assumes the core's pump levels and the system clock that paces the rf output
`timescale 1ns/1ps
`default_nettype none

module pdlc_vco_model (
	input wire logic sys_clk_i,
	input wire logic run_i,
	input wire logic [7:0] period_i,
	input wire logic pump_up_i,
	input wire logic pump_dn_i,
	input wire logic pump_hiz_i,
	output logic rf_o,
	output logic [15:0] tune_o
);
	logic [7:0] phase_cnt = 8'h00;
	logic rf_q = 1'b0;
	logic [15:0] tune_q = 16'h8000;

	// ---------------------------------------------------------------
	// rf waveform
	// ---------------------------------------------------------------
	// rate comes from period_i, not from tune_q: a limitation that keeps divider spans exact
	always @(posedge sys_clk_i) begin
		if (!run_i || phase_cnt >= period_i - 8'h01) begin
			phase_cnt <= 8'h00;
		end else begin
			phase_cnt <= phase_cnt + 8'h01;
		end
		rf_q <= run_i && (phase_cnt < (period_i >> 1));
	end

	// loop filter: pump levels integrate into a tuning word, high impedance holds it
	always @(posedge sys_clk_i) begin
		if (!pump_hiz_i && pump_up_i) begin
			tune_q <= tune_q + 16'h0001;
		end else if (!pump_hiz_i && pump_dn_i) begin
			tune_q <= tune_q - 16'h0001;
		end
	end

	assign rf_o = rf_q;
	assign tune_o = tune_q;
endmodule : pdlc_vco_model
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the synthesizer divider and lock core
// assumes the vco model on rf, a bench-made oscillator and an apb master on one clock
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int RF_P = 5;
	localparam int OSC_P = 6;
	localparam int WD_CYC = 70000;

	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, rf, pump_up, pump_dn, pump_hiz, pump_sel;
	logic vco_switch_a_unlock, vco_switch_a_unlock_oe_n, alarm, alarm_oe_n, vco_switch_b, div8;
	logic osc = 1'b0;
	logic hw_sleep_n = 1'b1;
	logic power_dip = 1'b0;
	logic osc_run = 1'b0;
	logic rf_run = 1'b0;
	logic [15:0] tune;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	int osc_cnt = 0;
	int osc_edges = 0;
	int dn_last = -1;

	pdlc_top dut (
		.sys_clk_i(sys_clk), .nrst_i(nrst), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .rf_i(rf), .osc_i(osc),
		.hw_sleep_n_i(hw_sleep_n), .power_dip_i(power_dip), .pump_up_o(pump_up),
		.pump_dn_o(pump_dn), .pump_hiz_o(pump_hiz), .pump_current_sel_o(pump_sel),
		.vco_switch_a_unlock_o(vco_switch_a_unlock), .vco_switch_a_unlock_oe_n_o(vco_switch_a_unlock_oe_n),
		.synth_alarm_n_o(alarm), .synth_alarm_n_oe_n_o(alarm_oe_n),
		.vco_switch_b_o(vco_switch_b), .osc_div8_out_o(div8)
	);

	pdlc_vco_model u_vco (
		.sys_clk_i(sys_clk), .run_i(rf_run), .period_i(8'(RF_P)), .pump_up_i(pump_up),
		.pump_dn_i(pump_dn), .pump_hiz_i(pump_hiz), .rf_o(rf), .tune_o(tune)
	);

	always #10 sys_clk = ~sys_clk;

	// ---------------------------------------------------------------
	// oscillator pin and bookkeeping
	// ---------------------------------------------------------------
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		osc_cnt <= (!osc_run || osc_cnt == OSC_P - 1) ? 0 : osc_cnt + 1;
		osc <= osc_run && (osc_cnt < OSC_P / 2);
		if (osc_run && osc_cnt == 0) begin
			osc_edges <= osc_edges + 1;
		end
		if (pump_dn === 1'b1) begin
			dn_last <= cyc;
		end
	end

	// ---------------------------------------------------------------
	// compares, bus cycles and waits
	// ---------------------------------------------------------------
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check_word

	task automatic check_bit(input string what, input logic exp, input logic got);
		check_word(what, {31'h0, exp}, {31'h0, got});
	endtask : check_bit

	// request held from setup until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check_bit("pready", 1'b1, pready);
	endtask : apb

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic [31:0] d;
		logic e;
		apb(1'b1, addr, {24'h000000, data}, d, e);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp,
		input logic exp_err);
		logic [31:0] d;
		logic e;
		apb(1'b0, addr, 32'h00000000, d, e);
		check_word(what, exp, d);
		check_bit(what, exp_err, e);
	endtask : rd_chk

	// sig 0 watches pump_up, anything else the divided oscillator pin
	task automatic wait_edge(input int sig, input logic to, output int at);
		logic prev;
		logic now;
		int n;
		n = 0;
		now = (sig == 0) ? pump_up : div8;
		do begin
			prev = now;
			@(posedge sys_clk);
			now = (sig == 0) ? pump_up : div8;
			n++;
		end while (!(prev === ~to && now === to) && n < 30000);
		at = cyc;
		check_bit("edge seen", to, now);
	endtask : wait_edge

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		check_bit("rst hiz", 1'b1, pump_hiz);
		check_bit("rst up", 1'b0, pump_up);
		check_bit("rst vco_switch_a_unlock", 1'b1, vco_switch_a_unlock_oe_n);
		check_bit("vco_switch_a_unlock data", 1'b0, vco_switch_a_unlock);
		check_bit("alarm data", 1'b0, alarm);
		check_bit("pump half", 1'b0, pump_sel);
		rd_chk("reg a", pdlc_pkg::OFF_A, 32'h0000000E, 1'b0);
		rd_chk("reg c", pdlc_pkg::OFF_C, 32'h00000000, 1'b0);
		rd_chk("unmapped", 8'h14, 32'h00000000, 1'b1);
		wr(pdlc_pkg::OFF_A, 8'h20);
		wr(pdlc_pkg::OFF_B, 8'h40);
		wr(pdlc_pkg::OFF_STAT, 8'hFF);
		rd_chk("reg a new", pdlc_pkg::OFF_A, 32'h00000020, 1'b0);
		check_bit("pump full", 1'b1, pump_sel);
		check_bit("vco b", 1'b1, vco_switch_b);
		power_dip <= 1'b1;
		repeat (4) @(posedge sys_clk);
		power_dip <= 1'b0;
		repeat (6) @(posedge sys_clk);
		check_bit("dip alarm", 1'b0, alarm_oe_n);
		rd_chk("dip status", pdlc_pkg::OFF_STAT, 32'h00000002, 1'b0);
		repeat (4) @(posedge sys_clk);
		check_bit("alarm free", 1'b1, alarm_oe_n);
	endtask : t_reset

	// reference runs far faster than the divider, so up falls exactly at divider pulses
	task automatic t_divider;
		int f1, f2, f3, f4, r1, r2, r3;
		osc_run <= 1'b1;
		rf_run <= 1'b1;
		wait_edge(0, 1'b0, f1);
		wait_edge(0, 1'b1, r1);
		repeat (14) @(posedge sys_clk);
		check_bit("up hiz", 1'b0, pump_hiz);
		check_bit("unlock pin", 1'b0, vco_switch_a_unlock_oe_n);
		check_bit("unlock alarm", 1'b0, alarm_oe_n);
		rd_chk("status", pdlc_pkg::OFF_STAT, 32'h00000014, 1'b0);
		check_bit("tune rose", 1'b1, tune > 16'h8000);
		wr(pdlc_pkg::OFF_C, 8'h01);
		wait_edge(0, 1'b0, f2);
		check_word("n 2048", 32'(2048 * RF_P), 32'(f2 - f1));
		wait_edge(0, 1'b1, r2);
		check_word("ref step", 32'h0, 32'((r2 - r1) % (128 * OSC_P)));
		wr(pdlc_pkg::OFF_D, 8'h64);
		wait_edge(0, 1'b0, f3);
		check_word("n kept", 32'(2048 * RF_P), 32'(f3 - f2));
		wait_edge(0, 1'b0, f4);
		check_word("n low", 32'((356 + 2048) * RF_P), 32'(f4 - f3));
		check_bit("no down", 1'b1, dn_last < f1);
		check_bit("unlock held", 1'b0, vco_switch_a_unlock_oe_n);
		wait_edge(0, 1'b1, r3);
		wr(pdlc_pkg::OFF_B, 8'hC0);
		repeat (6) @(posedge sys_clk);
		check_bit("swap up", 1'b0, pump_up);
		check_bit("swap dn", 1'b1, pump_dn);
	endtask : t_divider

	task automatic t_div8;
		int t, e0;
		wait_edge(2, 1'b1, t);
		e0 = osc_edges;
		wait_edge(2, 1'b1, t);
		check_word("osc per div8", 32'h00000008, 32'(osc_edges - e0));
	endtask : t_div8

	task automatic t_sleep;
		logic d8;
		hw_sleep_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		check_bit("sleep up", 1'b0, pump_up);
		check_bit("sleep dn", 1'b0, pump_dn);
		check_bit("sleep hiz", 1'b1, pump_hiz);
		d8 = div8;
		repeat (60) @(posedge sys_clk);
		check_bit("div8 frozen", d8, div8);
		rd_chk("d kept", pdlc_pkg::OFF_D, 32'h00000064, 1'b0);
		wr(pdlc_pkg::OFF_C, 8'h5A);
		rd_chk("c in sleep", pdlc_pkg::OFF_C, 32'h0000005A, 1'b0);
		hw_sleep_n <= 1'b1;
	endtask : t_sleep

	task automatic summarize;
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	// main sequence: reset held twelve cycles, then the scenarios in order
	initial begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		t_reset();
		t_divider();
		t_div8();
		t_sleep();
		summarize();
	end

	// watchdog: the scenarios need about 45000 cycles
	initial begin
		repeat (WD_CYC) @(posedge sys_clk);
		failures++;
		summarize();
	end
endmodule : tb_top
`default_nettype wire
